// ==== design/usb_port_pkg.sv ====
package usb_port_pkg;
  // clock rates
  localparam int CLK_KHZ        = 250000;
  localparam int SRC_KHZ        = 48000;
  localparam int SRC_PER_FS     = 4;
  localparam int SRC_PER_LS     = 32;
  // bit-time counts
  localparam int DEBOUNCE_BITS  = 30;
  localparam int EOP_SE0_BITS   = 16;
  localparam int EOP_J_BITS     = 8;
  // long timings
  localparam int RESET_TIME_MS   = 10;
  localparam int RESUME_TIME_MS  = 20;
  localparam int RECOVER_TIME_MS = 3;
  localparam int RESET_CYCLES    = RESET_TIME_MS * CLK_KHZ;
  localparam int RESUME_CYCLES   = RESUME_TIME_MS * CLK_KHZ;
  localparam int RECOVER_CYCLES  = RECOVER_TIME_MS * CLK_KHZ;
  localparam int TIMER_W         = 23;
  // register offsets
  localparam logic [3:0] ADDR_PORT = 4'h0;
  localparam logic [3:0] ADDR_HUB  = 4'h4;
  // port register write bits
  localparam int WB_DISABLE = 0;
  localparam int WB_ENABLE  = 1;
  localparam int WB_SUSPEND = 2;
  localparam int WB_RESUME  = 3;
  localparam int WB_RESET   = 4;
  // port register read bits
  localparam int RB_ATTACH    = 0;
  localparam int RB_ENABLED   = 1;
  localparam int RB_SUSPENDED = 2;
  localparam int RB_RST_ACT   = 4;
  localparam int RB_SLOW      = 9;
  localparam int CB_ATTACH    = 16;
  localparam int CB_SUSPEND   = 18;
  localparam int CB_RST_DONE  = 20;
  // hub register bits
  localparam int HB_STATE  = 0;
  localparam int HB_FIXED  = 2;
  localparam int HB_CHANGE = 3;
  // controller state field
  localparam logic [1:0] CTL_RESET   = 2'h0;
  localparam logic [1:0] CTL_RESUME  = 2'h1;
  localparam logic [1:0] CTL_OPER    = 2'h2;
  localparam logic [1:0] CTL_SUSPEND = 2'h3;
  localparam logic [1:0] CTL_RST_VAL = CTL_RESET;
  localparam logic       FIXED_RST_VAL = 1'h0;

  typedef enum logic [2:0] {
    PS_RUN, PS_RESET, PS_RESUME, PS_EOP, PS_RECOVER
  } port_state_type;
endpackage

// ==== design/usb_rate_gen.sv ====
`timescale 1ns/100ps
module usb_rate_gen
  import usb_port_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic run_i,
  input  wire logic ls_i,
  input  wire logic rx_active_i,
  input  wire logic rx_edge_i,
  // enables
  output logic      fs_en_o,
  output logic      bit_en_o
);
  localparam logic [8:0] ACC_STEP = 9'(SRC_KHZ / 1000);
  localparam logic [8:0] ACC_WRAP = 9'(CLK_KHZ / 1000);
  localparam logic [4:0] FS_LAST  = 5'(SRC_PER_FS - 1);
  localparam logic [4:0] LS_LAST  = 5'(SRC_PER_LS - 1);

  logic [8:0] acc_ff;
  logic [4:0] sc_ff;
  logic [4:0] rc_ff;
  logic [8:0] acc_sum;
  logic       tick;
  logic [4:0] rx_last;

  assign acc_sum = acc_ff + ACC_STEP;
  assign tick    = acc_sum >= ACC_WRAP;
  assign rx_last = ls_i ? LS_LAST : FS_LAST;

  // 48 MHz source tick by phase accumulation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_ff <= 9'h000;
    end else begin
      acc_ff <= tick ? acc_sum - ACC_WRAP : acc_sum;
    end
  end

  // static divider for frame and data rates
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sc_ff <= 5'h00;
    end else if (tick) begin
      sc_ff <= sc_ff + 5'h01;
    end
  end

  // receive phase counter, realigned on every line edge
  always_ff @(posedge clk_i) begin
    if (rst_i || rx_edge_i) begin
      rc_ff <= 5'h00;
    end else if (tick) begin
      rc_ff <= (rc_ff == rx_last) ? 5'h00 : rc_ff + 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_en_o  <= 1'b0;
      bit_en_o <= 1'b0;
    end else begin
      fs_en_o  <= run_i && tick && (sc_ff[1:0] == FS_LAST[1:0]);
      if (rx_active_i) begin
        bit_en_o <= run_i && tick && (rc_ff == (rx_last >> 1));
      end else if (ls_i) begin
        bit_en_o <= run_i && tick && (sc_ff == LS_LAST);
      end else begin
        bit_en_o <= run_i && tick && (sc_ff[1:0] == FS_LAST[1:0]);
      end
    end
  end
endmodule

// ==== design/usb_root_port.sv ====
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
// How it works
// - idle port declares attach after 30 bit times of non-SE0 line
// - detach declared after 30 bit times of continuous SE0
// - attach change flag set whenever the attach flag flips
// - slow device flag taken from line state at attach
// - low-speed device inverts transmit and receive bit streams
// - fixed device flag forces attach flag reads to one
// - after reset, normal attach detection sets change and slow flags
// - port commands without a device are ignored and set attach change
// - detach clears enabled and suspended flags
// - port reset drives SE0 10 ms, then enables and flags completion
// - enable only by command or reset end; disable if busy at EOF
// - disabled port forwards nothing, only detach is seen
// - enabled port forwards all; low speed downstream only after preamble
// - suspend command sets suspended; no downstream traffic then
// - suspended port wakes on resume command, J-to-K or detach
// - resume: 20 ms K, low-speed EOP, 3 ms forwarding, then flags
// - detach while suspended: no resume, set attach change, unsuspend
// - suspended port ignores controller resume; its wake forces resume
// - any change flag raises hub interrupt; write one clears it
// - 12 MHz frame clock from 48 MHz, stopped while controller state is suspended
// - data clock 1.5 MHz after preamble until response done
// - receive clock realigned to line edges, back to static after
// - controller state encodes reset, resume, operational, suspended
module usb_root_port
  import usb_port_pkg::*;
#(
  parameter int RESET_CYC   = RESET_CYCLES,
  parameter int RESUME_CYC  = RESUME_CYCLES,
  parameter int RECOVER_CYC = RECOVER_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // line pins
  input  wire logic        line_dp_i,
  input  wire logic        line_dm_i,
  output logic             line_dp_o,
  output logic             line_dm_o,
  output logic             line_oe_o,
  // serial engine
  input  wire logic        tx_valid_i,
  input  wire logic        tx_j_i,
  input  wire logic        tx_se0_i,
  input  wire logic        rx_active_i,
  input  wire logic        pre_token_i,
  input  wire logic        ls_done_i,
  input  wire logic        eof_i,
  output logic             rx_valid_o,
  output logic             rx_j_o,
  output logic             rx_se0_o,
  output logic             fs_en_o,
  output logic             bit_en_o,
  output logic             ls_mode_o,
  // hub status
  output logic             hub_change_o,
  output logic      [1:0]  controller_state_o,
  output logic             resume_seen_o
);
  localparam logic [4:0] DEB_LAST = 5'(DEBOUNCE_BITS);
  localparam logic [TIMER_W-1:0] EOP_LAST =
    TIMER_W'(EOP_SE0_BITS + EOP_J_BITS - 1);
  localparam logic [TIMER_W-1:0] EOP_J = TIMER_W'(EOP_J_BITS);

  port_state_type     st_ff;
  logic [TIMER_W-1:0] timer_ff;
  logic       dp_m_ff, dp_s_ff, dm_m_ff, dm_s_ff;
  logic [1:0] prev_ls_ff;
  logic       prev_j_ff;
  logic [4:0] deb_ff;
  logic       current_attach_flag_ff;
  logic       slow_device_flag_ff;
  logic       attach_change_flag_ff;
  logic       port_enabled_flag_ff;
  logic       port_suspended_flag_ff;
  logic       suspend_change_flag_ff;
  logic       reset_active_flag_ff;
  logic       reset_done_change_flag_ff;
  logic       fixed_device_flag_ff;
  logic [1:0] ctl_ff;
  logic       ls_win_ff;

  logic se0, line_j, line_k, settled, attach_evt, detach_evt;
  logic cmd_wr, cmd_any, cmd_ok, hub_wr, timer_zero;
  logic reset_end, recover_end, wake_line, start_resume, start_reset;
  logic eof_busy, down_ok, hub_k, rx_edge;

  // pin synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dp_m_ff <= 1'b0;
      dp_s_ff <= 1'b0;
      dm_m_ff <= 1'b0;
      dm_s_ff <= 1'b0;
    end else begin
      dp_m_ff <= line_dp_i;
      dp_s_ff <= dp_m_ff;
      dm_m_ff <= line_dm_i;
      dm_s_ff <= dm_m_ff;
    end
  end

  assign se0    = !dp_s_ff && !dm_s_ff;
  assign line_j = slow_device_flag_ff ? (dm_s_ff && !dp_s_ff)
                                      : (dp_s_ff && !dm_s_ff);
  assign line_k = slow_device_flag_ff ? (dp_s_ff && !dm_s_ff)
                                      : (dm_s_ff && !dp_s_ff);
  assign rx_edge = rx_active_i && (prev_ls_ff[1] != dp_s_ff);

  // debounce of attach and detach
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_ls_ff <= 2'h0;
      prev_j_ff  <= 1'b0;
      deb_ff     <= 5'h00;
    end else begin
      prev_ls_ff <= {dp_s_ff, dm_s_ff};
      prev_j_ff  <= line_j;
      if (line_oe_o || prev_ls_ff != {dp_s_ff, dm_s_ff}) begin
        deb_ff <= 5'h00;
      end else if (fs_en_o && deb_ff != DEB_LAST) begin
        deb_ff <= deb_ff + 5'h01;
      end
    end
  end

  assign settled    = deb_ff == DEB_LAST &&
                      prev_ls_ff == {dp_s_ff, dm_s_ff};
  assign attach_evt = settled && !se0 && !current_attach_flag_ff;
  assign detach_evt = settled && se0 && current_attach_flag_ff;

  // command decode
  assign cmd_wr  = wr_i && addr_i == ADDR_PORT;
  assign hub_wr  = wr_i && addr_i == ADDR_HUB;
  assign cmd_any = cmd_wr && (|wdata_i[WB_RESET:WB_DISABLE]);
  assign cmd_ok  = cmd_any && current_attach_flag_ff;
  assign timer_zero  = timer_ff == '0;
  assign reset_end   = st_ff == PS_RESET && timer_zero;
  assign recover_end = st_ff == PS_RECOVER && timer_zero && !detach_evt;
  assign start_reset = st_ff == PS_RUN && cmd_ok && wdata_i[WB_RESET];
  assign wake_line   = st_ff == PS_RUN && port_suspended_flag_ff &&
                       port_enabled_flag_ff && prev_j_ff && line_k;
  assign start_resume = st_ff == PS_RUN && port_suspended_flag_ff &&
                        !detach_evt && !start_reset &&
                        ((cmd_ok && wdata_i[WB_RESUME]) || wake_line);
  assign eof_busy = eof_i && st_ff == PS_RUN && !line_oe_o && !line_j;

  // port sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff    <= PS_RUN;
      timer_ff <= '0;
    end else begin
      case (st_ff)
        PS_RUN: begin
          if (start_reset) begin
            st_ff    <= PS_RESET;
            timer_ff <= TIMER_W'(RESET_CYC - 1);
          end else if (start_resume) begin
            st_ff    <= PS_RESUME;
            timer_ff <= TIMER_W'(RESUME_CYC - 1);
          end
        end
        PS_RESET, PS_RECOVER: begin
          if (timer_zero || detach_evt) begin
            st_ff <= PS_RUN;
          end else begin
            timer_ff <= timer_ff - 1'b1;
          end
        end
        PS_RESUME: begin
          if (timer_zero) begin
            st_ff    <= PS_EOP;
            timer_ff <= EOP_LAST;
          end else begin
            timer_ff <= timer_ff - 1'b1;
          end
        end
        PS_EOP: begin
          if (fs_en_o && timer_zero) begin
            st_ff    <= PS_RECOVER;
            timer_ff <= TIMER_W'(RECOVER_CYC - 1);
          end else if (fs_en_o) begin
            timer_ff <= timer_ff - 1'b1;
          end
        end
        default: begin
          st_ff <= PS_RUN;
        end
      endcase
    end
  end

  // attach state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      current_attach_flag_ff <= 1'b0;
      slow_device_flag_ff    <= 1'b0;
      attach_change_flag_ff  <= 1'b0;
    end else begin
      if (attach_evt) begin
        current_attach_flag_ff <= 1'b1;
        slow_device_flag_ff    <= dm_s_ff;
      end else if (detach_evt) begin
        current_attach_flag_ff <= 1'b0;
      end
      if (attach_evt || detach_evt || (cmd_any && !current_attach_flag_ff))
        attach_change_flag_ff <= 1'b1;
      else if (cmd_wr && wdata_i[CB_ATTACH])
        attach_change_flag_ff <= 1'b0;
    end
  end

  // enable, suspend and reset flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_enabled_flag_ff      <= 1'b0;
      port_suspended_flag_ff    <= 1'b0;
      suspend_change_flag_ff    <= 1'b0;
      reset_active_flag_ff      <= 1'b0;
      reset_done_change_flag_ff <= 1'b0;
    end else begin
      if (detach_evt || eof_busy) begin
        port_enabled_flag_ff <= 1'b0;
      end else if (reset_end || (cmd_ok && wdata_i[WB_ENABLE])) begin
        port_enabled_flag_ff <= 1'b1;
      end else if (cmd_ok && wdata_i[WB_DISABLE]) begin
        port_enabled_flag_ff <= 1'b0;
      end
      if (detach_evt || reset_end || recover_end) begin
        port_suspended_flag_ff <= 1'b0;
      end else if (cmd_ok && wdata_i[WB_SUSPEND]) begin
        port_suspended_flag_ff <= 1'b1;
      end
      if (reset_end) begin
        suspend_change_flag_ff <= 1'b0;
      end else if (recover_end) begin
        suspend_change_flag_ff <= 1'b1;
      end else if (cmd_wr && wdata_i[CB_SUSPEND]) begin
        suspend_change_flag_ff <= 1'b0;
      end
      if (start_reset) begin
        reset_active_flag_ff <= 1'b1;
      end else if (st_ff != PS_RESET) begin
        reset_active_flag_ff <= 1'b0;
      end
      if (reset_end) begin
        reset_done_change_flag_ff <= 1'b1;
      end else if (cmd_wr && wdata_i[CB_RST_DONE]) begin
        reset_done_change_flag_ff <= 1'b0;
      end
    end
  end

  // hub control and controller state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_ff               <= CTL_RST_VAL;
      fixed_device_flag_ff <= FIXED_RST_VAL;
      resume_seen_o        <= 1'b0;
    end else begin
      resume_seen_o <= ctl_ff == CTL_SUSPEND && wake_line;
      if (ctl_ff == CTL_SUSPEND && wake_line) begin
        ctl_ff <= CTL_RESUME;
      end else if (hub_wr) begin
        ctl_ff <= wdata_i[HB_STATE +: 2];
      end
      if (hub_wr) begin
        fixed_device_flag_ff <= wdata_i[HB_FIXED];
      end
    end
  end

  assign hub_change_o = attach_change_flag_ff || suspend_change_flag_ff ||
                        reset_done_change_flag_ff;
  assign controller_state_o = ctl_ff;

  // low-speed window after a preamble
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ls_win_ff <= 1'b0;
    end else if (ls_done_i || detach_evt) begin
      ls_win_ff <= 1'b0;
    end else if (pre_token_i) begin
      ls_win_ff <= 1'b1;
    end
  end

  assign ls_mode_o = slow_device_flag_ff && ls_win_ff;
  assign down_ok   = port_enabled_flag_ff &&
                     ((st_ff == PS_RUN && !port_suspended_flag_ff) ||
                      st_ff == PS_RECOVER) &&
                     (!slow_device_flag_ff || ls_win_ff);
  assign hub_k     = ctl_ff == CTL_RESUME && port_enabled_flag_ff &&
                     !port_suspended_flag_ff && st_ff == PS_RUN;

  // line drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_dp_o <= 1'b0;
      line_dm_o <= 1'b0;
      line_oe_o <= 1'b0;
    end else begin
      line_oe_o <= 1'b1;
      case (st_ff)
        PS_RESET: begin
          line_dp_o <= 1'b0;
          line_dm_o <= 1'b0;
        end
        PS_RESUME: begin
          line_dp_o <= slow_device_flag_ff;
          line_dm_o <= !slow_device_flag_ff;
        end
        PS_EOP: begin
          line_dp_o <= timer_ff < EOP_J && !slow_device_flag_ff;
          line_dm_o <= timer_ff < EOP_J && slow_device_flag_ff;
        end
        default: begin
          if (hub_k) begin
            line_dp_o <= slow_device_flag_ff;
            line_dm_o <= !slow_device_flag_ff;
          end else if (down_ok && tx_valid_i) begin
            line_dp_o <= !tx_se0_i && (tx_j_i ^ slow_device_flag_ff);
            line_dm_o <= !tx_se0_i && !(tx_j_i ^ slow_device_flag_ff);
          end else begin
            line_oe_o <= 1'b0;
            line_dp_o <= 1'b0;
            line_dm_o <= 1'b0;
          end
        end
      endcase
    end
  end

  // upstream forwarding
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_valid_o <= 1'b0;
      rx_j_o     <= 1'b0;
      rx_se0_o   <= 1'b0;
    end else begin
      rx_valid_o <= port_enabled_flag_ff && !line_oe_o;
      rx_j_o     <= dp_s_ff ^ slow_device_flag_ff;
      rx_se0_o   <= se0;
    end
  end

  usb_rate_gen usb_rate_gen_inst (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .run_i       (ctl_ff != CTL_SUSPEND),
    .ls_i        (ls_mode_o),
    .rx_active_i (rx_active_i),
    .rx_edge_i   (rx_edge),
    .fs_en_o     (fs_en_o),
    .bit_en_o    (bit_en_o)
  );

  // register read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= 32'h0000_0000;
      if (rd_i && addr_i == ADDR_PORT) begin
        rdata_o[RB_ATTACH] <= current_attach_flag_ff ||
                              fixed_device_flag_ff;
        rdata_o[RB_ENABLED]   <= port_enabled_flag_ff;
        rdata_o[RB_SUSPENDED] <= port_suspended_flag_ff;
        rdata_o[RB_RST_ACT]   <= reset_active_flag_ff;
        rdata_o[RB_SLOW]      <= slow_device_flag_ff;
        rdata_o[CB_ATTACH]    <= attach_change_flag_ff;
        rdata_o[CB_SUSPEND]   <= suspend_change_flag_ff;
        rdata_o[CB_RST_DONE]  <= reset_done_change_flag_ff;
      end else if (rd_i && addr_i == ADDR_HUB) begin
        rdata_o[HB_STATE +: 2] <= ctl_ff;
        rdata_o[HB_FIXED]      <= fixed_device_flag_ff;
        rdata_o[HB_CHANGE]     <= hub_change_o;
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_attach_change;
    $changed(current_attach_flag_ff) |-> attach_change_flag_ff;
  endproperty
  a_attach_change: assert property (p_attach_change)
    else $error("attach flip without change flag");

  property p_fixed_read;
    rd_i && addr_i == ADDR_PORT && fixed_device_flag_ff |=> rdata_o[0];
  endproperty
  a_fixed_read: assert property (p_fixed_read)
    else $error("fixed port read attach as zero");

  property p_detach_clear;
    $fell(current_attach_flag_ff) |->
      !port_enabled_flag_ff && !port_suspended_flag_ff;
  endproperty
  a_detach_clear: assert property (p_detach_clear)
    else $error("detach left port enabled or suspended");

  property p_reset_end;
    $fell(reset_active_flag_ff) && current_attach_flag_ff |->
      port_enabled_flag_ff && reset_done_change_flag_ff &&
      !port_suspended_flag_ff;
  endproperty
  a_reset_end: assert property (p_reset_end)
    else $error("port reset end did not enable port");

  property p_no_device_cmd;
    cmd_any && !current_attach_flag_ff && !attach_evt |=>
      attach_change_flag_ff && $stable(port_enabled_flag_ff) &&
      st_ff == PS_RUN;
  endproperty
  a_no_device_cmd: assert property (p_no_device_cmd)
    else $error("command acted on empty port");

  property p_frame_stop;
    (ctl_ff == CTL_SUSPEND) [*2] |-> !fs_en_o && !bit_en_o;
  endproperty
  a_frame_stop: assert property (p_frame_stop)
    else $error("frame clock ran while suspended");

  property p_disabled_quiet;
    !port_enabled_flag_ff |=> !rx_valid_o && !(line_oe_o && st_ff == PS_RUN
      && $past(st_ff) == PS_RUN && !$past(hub_k));
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("disabled port forwarded traffic");

  property p_suspend_quiet;
    port_suspended_flag_ff && st_ff == PS_RUN |-> !down_ok && !hub_k;
  endproperty
  a_suspend_quiet: assert property (p_suspend_quiet)
    else $error("suspended port forwarded downstream");
endmodule

// ==== testbench/usb_dev_model.sv ====
`timescale 1ns/100ps
module usb_dev_model (
  // device control
  input  wire logic attach_i,
  input  wire logic slow_i,
  input  wire logic wake_i,
  // port drive
  input  wire logic port_dp_i,
  input  wire logic port_dm_i,
  input  wire logic port_oe_i,
  // wire levels
  output logic      dp_o,
  output logic      dm_o
);
  // wire level: port drive wins, pull-downs when absent
  always_comb begin
    if (port_oe_i) begin
      dp_o = port_dp_i;
      dm_o = port_dm_i;
    end else if (!attach_i) begin
      dp_o = 1'b0;
      dm_o = 1'b0;
    end else begin
      // idle j, or k while waking; low speed swaps lines
      dp_o = slow_i ^ ~wake_i;
      dm_o = ~(slow_i ^ ~wake_i);
    end
  end
endmodule

// ==== testbench/test_usb_root_port.sv ====
`timescale 1ns/100ps
module test_usb_root_port
  import usb_port_pkg::*;
;
  localparam logic [31:0] PM = 32'h0015_0217;
  logic        clk_i, rst_i, wr_i, rd_i;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic        dp, dm, dp_o, dm_o, oe_o, att, slow, wake;
  logic        tx_valid_i, rx_active_i, pre_token_i, ls_done_i, eof_i;
  logic        rx_valid_o, rx_j_o, hub_change_o;
  logic        tx_j, rx_se0, fs_en, bit_en, ls_mode, resume_seen, seen_wake;
  logic [1:0]  ctl_state;
  logic [31:0] fs_cnt, bit_cnt, fs0, bit0;
  int          fail_count, tests_run;

  usb_root_port #(.RESET_CYC(40), .RESUME_CYC(60), .RECOVER_CYC(30))
    usb_root_port_inst (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .line_dp_i(dp),
    .line_dm_i(dm), .line_dp_o(dp_o), .line_dm_o(dm_o), .line_oe_o(oe_o),
    .tx_valid_i(tx_valid_i), .tx_j_i(tx_j), .tx_se0_i(1'b0),
    .rx_active_i(rx_active_i), .pre_token_i(pre_token_i),
    .ls_done_i(ls_done_i), .eof_i(eof_i), .rx_valid_o(rx_valid_o),
    .rx_j_o(rx_j_o), .rx_se0_o(rx_se0), .fs_en_o(fs_en),
    .bit_en_o(bit_en), .ls_mode_o(ls_mode), .hub_change_o(hub_change_o),
    .controller_state_o(ctl_state), .resume_seen_o(resume_seen));

  usb_dev_model usb_dev_model_inst (
    .attach_i(att), .slow_i(slow), .wake_i(wake), .port_dp_i(dp_o),
    .port_dm_i(dm_o), .port_oe_i(oe_o), .dp_o(dp), .dm_o(dm));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [31:0] m, exp);
    logic [31:0] d;
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
    check(nm, d & m, exp);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // pulse counters and wake capture
  always @(posedge clk_i) begin
    if (rst_i) begin
      {fs_cnt, bit_cnt, seen_wake} <= '0;
    end else begin
      fs_cnt    <= fs_cnt + fs_en;
      bit_cnt   <= bit_cnt + bit_en;
      seen_wake <= seen_wake || resume_seen;
    end
  end

  initial begin
    #100000;
    fail_count++;
    final_report();
  end

  initial begin
    {rst_i, wr_i, rd_i, addr_i, wdata_i} = '0;
    {att, slow, wake, tx_valid_i, rx_active_i} = '0;
    {pre_token_i, ls_done_i, eof_i, tx_j} = '0;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk("port_reset_val", ADDR_PORT, 32'hFFFF_FFFF, 32'h0);
    rchk("hub_reset_val", ADDR_HUB, 32'hF, 32'h0);
    wr(ADDR_PORT, 32'h0000_0002);
    rchk("cmd_no_device", ADDR_PORT, PM, 32'h0001_0000);
    check("irq_set", {31'h0, hub_change_o}, 32'h1);
    wr(ADDR_PORT, 32'h0001_0000);
    wait_cyc(2);
    check("irq_clear", {31'h0, hub_change_o}, 32'h0);
    att <= 1'b1;
    wait_cyc(100);
    rchk("attach_early", ADDR_PORT, 32'h1, 32'h0);
    wait_cyc(700);
    rchk("fs_attach", ADDR_PORT, PM, 32'h0001_0001);
    wr(ADDR_PORT, 32'h0001_0010);
    wait_cyc(3);
    check("reset_se0", {29'h0, oe_o, dp_o, dm_o}, 32'h4);
    rchk("reset_active", ADDR_PORT, PM, 32'h0000_0011);
    wait_cyc(60);
    rchk("reset_end", ADDR_PORT, PM, 32'h0010_0003);
    wr(ADDR_PORT, 32'h0010_0000);
    wait_cyc(4);
    check("rx_forward", {30'h0, rx_valid_o, rx_j_o}, 32'h3);
    eof_i <= 1'b1;
    @(posedge clk_i);
    eof_i <= 1'b0;
    rchk("eof_idle", ADDR_PORT, PM, 32'h0000_0003);
    wr(ADDR_PORT, 32'h0000_0004);
    rchk("suspend", ADDR_PORT, PM, 32'h0000_0007);
    wr(ADDR_PORT, 32'h0000_0008);
    wait_cyc(3);
    check("resume_k", {29'h0, oe_o, dp_o, dm_o}, 32'h5);
    wait_cyc(800);
    rchk("resume_end", ADDR_PORT, PM, 32'h0004_0003);
    wr(ADDR_PORT, 32'h0004_0000);
    wr(ADDR_PORT, 32'h0000_0004);
    att <= 1'b0;
    wait_cyc(800);
    rchk("susp_detach", ADDR_PORT, PM, 32'h0001_0000);
    check("rx_blocked", {31'h0, rx_valid_o}, 32'h0);
    check("rx_se0", {31'h0, rx_se0}, 32'h1);
    wr(ADDR_PORT, 32'h0001_0000);
    wr(ADDR_HUB, 32'h0000_0006);
    rchk("hub_rw", ADDR_HUB, 32'h7, 32'h6);
    rchk("fixed_attach", ADDR_PORT, 32'h1, 32'h1);
    wr(ADDR_HUB, 32'h0000_0002);
    slow <= 1'b1;
    att  <= 1'b1;
    wait_cyc(800);
    rchk("ls_attach", ADDR_PORT, PM, 32'h0001_0201);
    wr(ADDR_PORT, 32'h0001_0010);
    wait_cyc(60);
    @(posedge clk_i);
    tx_valid_i <= 1'b1;
    wait_cyc(3);
    check("ls_no_pre", {31'h0, oe_o}, 32'h0);
    @(posedge clk_i);
    pre_token_i <= 1'b1;
    @(posedge clk_i);
    pre_token_i <= 1'b0;
    wait_cyc(3);
    check("ls_tx", {29'h0, oe_o, dp_o, dm_o}, 32'h6);
    check("ls_mode", {31'h0, ls_mode}, 32'h1);
    fs0  = fs_cnt;
    bit0 = bit_cnt;
    wait_cyc(1000);
    check("ls_rate", bit_cnt - bit0, 32'h6);
    check("frame_rate", fs_cnt - fs0, 32'h30);
    @(posedge clk_i);
    {tx_valid_i, ls_done_i} <= 2'b01;
    @(posedge clk_i);
    ls_done_i <= 1'b0;
    wait_cyc(1);
    check("ls_done", {31'h0, ls_mode}, 32'h0);
    wr(ADDR_PORT, 32'h0010_0004);
    wr(ADDR_HUB, 32'h0000_0003);
    wait_cyc(2);
    fs0 = fs_cnt;
    wait_cyc(250);
    check("susp_frame", fs_cnt - fs0, 32'h0);
    @(posedge clk_i);
    wake <= 1'b1;
    wait_cyc(20);
    check("wake_state", {30'h0, ctl_state}, 32'h1);
    check("wake_seen", {31'h0, seen_wake}, 32'h1);
    wake <= 1'b0;
    wait_cyc(800);
    rchk("wake_resume", ADDR_PORT, PM, 32'h0004_0203);
    wr(ADDR_HUB, 32'h0000_0002);
    wr(ADDR_PORT, 32'h0004_0000);
    wake <= 1'b1;
    wait_cyc(4);
    @(posedge clk_i);
    eof_i <= 1'b1;
    @(posedge clk_i);
    eof_i <= 1'b0;
    rchk("eof_busy", ADDR_PORT, PM, 32'h0000_0201);
    wake <= 1'b0;
    rchk("unmapped", 4'h8, 32'hFFFF_FFFF, 32'h0);
    final_report();
  end
endmodule
